// ---- logic/dma_desc_pkg.sv ----
// constants, register map and state type of the descriptor stream controller
`default_nettype none
package dma_desc_pkg;

  // descriptor instruction layout
  localparam int DESC_W = 160;
  localparam int WORD_W = 32;
  localparam int SRC_LO_LSB = 0;
  localparam int SRC_HI_LSB = 32;
  localparam int DST_LO_LSB = 64;
  localparam int DST_HI_LSB = 96;
  localparam int LEN_LSB = 128;
  localparam int LEN_W = 18;
  localparam int TAG_LSB = 146;
  localparam int TAG_W = 8;
  localparam int RSVD_LSB = 154;
  localparam int RSVD_W = 5;
  localparam int IMM_BIT = 159;

  // status word layout
  localparam int STAT_DONE_BIT = 8;
  localparam int STAT_KEEP_W = 9;

  // instruction port handshake
  localparam int READY_LATENCY = 3;
  localparam int HIST_W = READY_LATENCY - 1;

  // channels
  localparam int NUM_CH = 2;
  localparam int CH_RD = 0;
  localparam int CH_WR = 1;

  // register byte offsets
  localparam logic [7:0] REG_SRC_LO = 8'h00;
  localparam logic [7:0] REG_SRC_HI = 8'h04;
  localparam logic [7:0] REG_DST_LO = 8'h08;
  localparam logic [7:0] REG_DST_HI = 8'h0C;
  localparam logic [7:0] REG_LEN = 8'h10;
  localparam logic [7:0] REG_TAG = 8'h14;
  localparam logic [7:0] REG_CMD = 8'h18;
  localparam logic [7:0] REG_STATE = 8'h1C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK = 8'h24;
  localparam logic [7:0] REG_RD_LAST = 8'h28;
  localparam logic [7:0] REG_WR_LAST = 8'h2C;

  // register fields
  localparam int TAGREG_IMM_BIT = 8;
  localparam int IRQ_RD_DONE = 0;
  localparam int IRQ_WR_DONE = 1;
  localparam int IRQ_REJECT = 2;
  localparam int IRQ_W = 3;

  typedef enum logic [1:0]
  {
    CH_IDLE = 2'b00,
    CH_WAIT = 2'b01,
    CH_SEND = 2'b11
  } chState_t;

  typedef struct packed
  {
    logic ack;
    logic [WORD_W-1:0] rdData;
    logic [WORD_W-1:0] srcLo;
    logic [WORD_W-1:0] srcHi;
    logic [WORD_W-1:0] dstLo;
    logic [WORD_W-1:0] dstHi;
    logic [LEN_W-1:0] len;
    logic [TAG_W-1:0] tag;
    logic imm;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic irq;
    logic [NUM_CH-1:0][STAT_KEEP_W-1:0] last;
    chState_t [NUM_CH-1:0] st;
    logic [NUM_CH-1:0][DESC_W-1:0] desc;
    logic [NUM_CH-1:0] valid;
    logic [NUM_CH-1:0][HIST_W-1:0] hist;
  } ctrlState_t;

endpackage
`default_nettype wire

// ---- logic/dma_descriptor_stream_port.sv ----
// descriptor controller driving the read and write engine instruction ports
`timescale 1ns/1ps
`default_nettype none

// Operation
// - each transfer leaves as one 160-bit descriptor word
// - read port: valid only three cycles after ready was seen
// - write port: same three-cycle ready latency discipline
// - valid high exactly in the cycle holding the descriptor
// - bits 31:0 source low address, dword aligned
// - bits 63:32 source high address
// - bits 95:64 destination low address, dword aligned
// - bits 127:96 destination high address
// - bits 145:128 dword length, nonzero, at most 1 MB minus 4
// - bits 153:146 carry the transfer tag
// - immediate write payload sits in the source low field
module dma_descriptor_stream_port
  import dma_desc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output wire logic [31:0] wb_dat_o,
  output wire logic wb_ack_o,
  output wire logic irq,
  output wire logic [DESC_W-1:0] rdDescInBus,
  output wire logic rdDescInValid,
  input wire logic rdDescInReady,
  output wire logic [DESC_W-1:0] wrDescInBus,
  output wire logic wrDescInValid,
  input wire logic wrDescInReady,
  input wire logic [WORD_W-1:0] rdStatusOutBus,
  input wire logic rdStatusOutValid,
  input wire logic [WORD_W-1:0] wrStatusOutBus,
  input wire logic wrStatusOutValid
);

  // ----------------------------------------------------------------
  // state and channel views
  // ----------------------------------------------------------------
  ctrlState_t s_q;
  ctrlState_t s_d;
  logic [NUM_CH-1:0] readyIn;
  logic [NUM_CH-1:0] statValid;
  logic [NUM_CH-1:0][WORD_W-1:0] statBus;

  assign readyIn = {wrDescInReady, rdDescInReady};
  assign statValid = {wrStatusOutValid, rdStatusOutValid};
  assign statBus = {wrStatusOutBus, rdStatusOutBus};

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [WORD_W-1:0] mergeBytes(
    input logic [WORD_W-1:0] oldVal,
    input logic [WORD_W-1:0] newVal,
    input logic [3:0] sel
  );
    logic [WORD_W-1:0] r;
    r = oldVal;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[8*b +: 8] = newVal[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [DESC_W-1:0] buildDesc(
    input ctrlState_t s,
    input logic immWrite
  );
    logic [DESC_W-1:0] d;
    d = '0;
    d[SRC_LO_LSB +: WORD_W] = s.srcLo;
    d[SRC_HI_LSB +: WORD_W] = s.srcHi;
    d[DST_LO_LSB +: WORD_W] = s.dstLo;
    d[DST_HI_LSB +: WORD_W] = s.dstHi;
    d[LEN_LSB +: LEN_W] = s.len;
    d[TAG_LSB +: TAG_W] = s.tag;
    d[RSVD_LSB +: RSVD_W] = '0;
    d[IMM_BIT] = immWrite;
    return d;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic req;
    logic wrEn;
    logic [WORD_W-1:0] rd;
    logic [NUM_CH-1:0] launch;
    logic [NUM_CH-1:0] descOk;
    logic [IRQ_W-1:0] clr;
    logic [IRQ_W-1:0] set;
    logic immWr;
    req = 1'b0;
    wrEn = 1'b0;
    rd = '0;
    launch = '0;
    descOk = '0;
    clr = '0;
    set = '0;
    immWr = 1'b0;
    s_d = s_q;

    // wishbone slave: one-cycle answer, unmapped reads zero
    req = wb_cyc_i && wb_stb_i && !s_q.ack;
    wrEn = req && wb_we_i;
    s_d.ack = req;

    if (wb_adr_i == REG_SRC_LO)
    begin
      rd = s_q.srcLo;
    end
    else if (wb_adr_i == REG_SRC_HI)
    begin
      rd = s_q.srcHi;
    end
    else if (wb_adr_i == REG_DST_LO)
    begin
      rd = s_q.dstLo;
    end
    else if (wb_adr_i == REG_DST_HI)
    begin
      rd = s_q.dstHi;
    end
    else if (wb_adr_i == REG_LEN)
    begin
      rd[LEN_W-1:0] = s_q.len;
    end
    else if (wb_adr_i == REG_TAG)
    begin
      rd[TAG_W-1:0] = s_q.tag;
      rd[TAGREG_IMM_BIT] = s_q.imm;
    end
    else if (wb_adr_i == REG_STATE)
    begin
      rd[3:0] = {s_q.st[CH_WR], s_q.st[CH_RD]};
      rd[5:4] = readyIn;
    end
    else if (wb_adr_i == REG_IRQ_STAT)
    begin
      rd[IRQ_W-1:0] = s_q.irqStat;
    end
    else if (wb_adr_i == REG_IRQ_MASK)
    begin
      rd[IRQ_W-1:0] = s_q.irqMask;
    end
    else if (wb_adr_i == REG_RD_LAST)
    begin
      rd[STAT_KEEP_W-1:0] = s_q.last[CH_RD];
    end
    else if (wb_adr_i == REG_WR_LAST)
    begin
      rd[STAT_KEEP_W-1:0] = s_q.last[CH_WR];
    end
    if (req)
    begin
      s_d.rdData = wb_we_i ? '0 : rd;
    end

    if (wrEn)
    begin
      if (wb_adr_i == REG_SRC_LO)
      begin
        s_d.srcLo = mergeBytes(s_q.srcLo, wb_dat_i, wb_sel_i);
      end
      else if (wb_adr_i == REG_SRC_HI)
      begin
        s_d.srcHi = mergeBytes(s_q.srcHi, wb_dat_i, wb_sel_i);
      end
      else if (wb_adr_i == REG_DST_LO)
      begin
        s_d.dstLo = mergeBytes(s_q.dstLo, wb_dat_i, wb_sel_i);
      end
      else if (wb_adr_i == REG_DST_HI)
      begin
        s_d.dstHi = mergeBytes(s_q.dstHi, wb_dat_i, wb_sel_i);
      end
      else if (wb_adr_i == REG_LEN)
      begin
        s_d.len = LEN_W'(mergeBytes(WORD_W'(s_q.len), wb_dat_i, wb_sel_i));
      end
      else if (wb_adr_i == REG_TAG)
      begin
        if (wb_sel_i[0])
        begin
          s_d.tag = wb_dat_i[TAG_W-1:0];
        end
        if (wb_sel_i[1])
        begin
          s_d.imm = wb_dat_i[TAGREG_IMM_BIT];
        end
      end
      else if (wb_adr_i == REG_CMD)
      begin
        launch = wb_dat_i[NUM_CH-1:0] & {NUM_CH{wb_sel_i[0]}};
      end
      else if (wb_adr_i == REG_IRQ_STAT)
      begin
        clr = wb_dat_i[IRQ_W-1:0] & {IRQ_W{wb_sel_i[0]}};
      end
      else if (wb_adr_i == REG_IRQ_MASK)
      begin
        if (wb_sel_i[0])
        begin
          s_d.irqMask = wb_dat_i[IRQ_W-1:0];
        end
      end
    end

    // length nonzero; 18 bits cannot exceed the maximum
    // immediate payload in source low is not an address
    immWr = s_q.imm;
    descOk[CH_RD] = (s_q.len != '0) && (s_q.srcLo[1:0] == 2'b00) && (s_q.dstLo[1:0] == 2'b00);
    descOk[CH_WR] = (s_q.len != '0) && (s_q.dstLo[1:0] == 2'b00) && (immWr || (s_q.srcLo[1:0] == 2'b00));

    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      // ready history, bit HIST_W-1 is ready of two cycles back
      s_d.hist[ch] = {s_q.hist[ch][HIST_W-2:0], readyIn[ch]};

      case (s_q.st[ch])
        CH_IDLE:
        begin
          if (launch[ch] && descOk[ch])
          begin
            // read engine: host source, local destination
            // write engine: local source, host destination
            s_d.desc[ch] = buildDesc(s_q, (ch == CH_WR) ? immWr : 1'b0);
            s_d.st[ch] = CH_WAIT;
          end
          else if (launch[ch])
          begin
            set[IRQ_REJECT] = 1'b1;
          end
        end
        CH_WAIT:
        begin
          if (launch[ch])
          begin
            set[IRQ_REJECT] = 1'b1;
          end
          // read slot three cycles after ready
          // write slot three cycles after ready
          if (s_q.hist[ch][HIST_W-1])
          begin
            s_d.st[ch] = CH_SEND;
          end
        end
        CH_SEND:
        begin
          if (launch[ch])
          begin
            set[IRQ_REJECT] = 1'b1;
          end
          s_d.st[ch] = CH_IDLE;
        end
        default:
        begin
          s_d.st[ch] = CH_IDLE;
        end
      endcase

      // valid only in the descriptor cycle
      s_d.valid[ch] = (s_d.st[ch] == CH_SEND);

      if (statValid[ch])
      begin
        s_d.last[ch] = statBus[ch][STAT_KEEP_W-1:0];
        if (statBus[ch][STAT_DONE_BIT])
        begin
          set[ch] = 1'b1;
        end
      end
    end

    // sticky events: a set in the clearing cycle wins
    s_d.irqStat = (s_q.irqStat & ~clr) | set;
    s_d.irq = |(s_d.irqStat & s_d.irqMask);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o = s_q.rdData;
  assign wb_ack_o = s_q.ack;
  assign irq = s_q.irq;
  assign rdDescInBus = s_q.desc[CH_RD];
  assign rdDescInValid = s_q.valid[CH_RD];
  assign wrDescInBus = s_q.desc[CH_WR];
  assign wrDescInValid = s_q.valid[CH_WR];

endmodule
`default_nettype wire

// ---- testbench/dma_descriptor_stream_port_monitor.sv ----
// port checker for the descriptor stream controller
`timescale 1ns/1ps
`default_nettype none
module dma_descriptor_stream_port_monitor
  import dma_desc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [DESC_W-1:0] rdDescInBus,
  input wire logic rdDescInValid,
  input wire logic rdDescInReady,
  input wire logic [DESC_W-1:0] wrDescInBus,
  input wire logic wrDescInValid,
  input wire logic wrDescInReady
);
  default clocking mon @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  sequence wbReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_WB_ACK: assert property (wbReq |=> ackPulse)
    else $error("bus access not answered by one ack");
  AST_WB_HOLE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i > 8'h2C
    |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_RD_LAT: assert property (rdDescInValid |-> $past(rdDescInReady, 3))
    else $error("read descriptor outside ready slot");
  AST_WR_LAT: assert property (wrDescInValid |-> $past(wrDescInReady, 3))
    else $error("write descriptor outside ready slot");
  AST_RD_BEAT: assert property (rdDescInValid |=> !rdDescInValid)
    else $error("read valid longer than one beat");
  AST_WR_BEAT: assert property (wrDescInValid |=> !wrDescInValid)
    else $error("write valid longer than one beat");
  AST_RD_FIELDS: assert property (rdDescInValid |-> rdDescInBus[1:0] == 2'h0
    && rdDescInBus[65:64] == 2'h0 && rdDescInBus[145:128] != 18'h0 && rdDescInBus[159:154] == 6'h0)
    else $error("bad read descriptor fields");
  AST_WR_FIELDS: assert property (wrDescInValid |-> wrDescInBus[65:64] == 2'h0
    && wrDescInBus[145:128] != 18'h0 && wrDescInBus[158:154] == 5'h0
    && (wrDescInBus[159] || wrDescInBus[1:0] == 2'h0))
    else $error("bad write descriptor fields");
endmodule
`default_nettype wire

// ---- testbench/engine_model.sv ----
// behavioural engine answering one descriptor instruction port
`timescale 1ns/1ps
`default_nettype none
module engine_model
  import dma_desc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic holdOff,
  input wire logic [DESC_W-1:0] descBus,
  input wire logic descValid,
  output logic descReady,
  output logic [WORD_W-1:0] statBus,
  output logic statValid,
  output logic [DESC_W-1:0] lastDesc,
  output logic [7:0] takenCnt
);
  logic [3:0] busy;
  always_ff @(posedge clk_sys)
  begin
    statValid <= 1'b0;
    // idle status lines toggle every cycle, showing the last word on every second cycle
    statBus <= ~statBus;
    if (!reset_n)
    begin
      busy <= 4'h0;
      takenCnt <= 8'h0;
      statBus <= 32'h0;
      lastDesc <= '0;
    end
    else if (descValid)
    begin
      lastDesc <= descBus;
      takenCnt <= takenCnt + 8'h1;
      busy <= 4'h4;
    end
    else if (busy != 4'h0)
    begin
      busy <= busy - 4'h1;
      if (busy == 4'h1)
      begin
        statValid <= 1'b1;
        statBus <= {23'h0, 1'b1, lastDesc[153:146]};
      end
    end
    descReady <= reset_n && busy == 4'h0 && !descValid && !holdOff;
  end
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the descriptor stream controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dma_desc_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h0;
  logic [31:0] wbDatI = 32'h0;
  logic holdWr = 1'b0;
  logic [31:0] wbDatO;
  logic wbAck, irq, rdValid, wrValid, rdReady, wrReady, rdStV, wrStV;
  logic [DESC_W-1:0] rdBus, wrBus, rdLast, wrLast, exp;
  logic [WORD_W-1:0] rdSt, wrSt;
  logic [7:0] rdCnt, wrCnt;
  int err_total = 0;
  int cmp_count = 0;
  always #25 clk_sys = ~clk_sys;
  dma_descriptor_stream_port u_dma_descriptor_stream_port (.clk_sys(clk_sys), .reset_n(reset_n),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .irq(irq), .rdDescInBus(rdBus),
    .rdDescInValid(rdValid), .rdDescInReady(rdReady), .wrDescInBus(wrBus), .wrDescInValid(wrValid),
    .wrDescInReady(wrReady), .rdStatusOutBus(rdSt), .rdStatusOutValid(rdStV), .wrStatusOutBus(wrSt),
    .wrStatusOutValid(wrStV));
  engine_model u_engine_model_rd (.clk_sys(clk_sys), .reset_n(reset_n), .holdOff(1'b0), .descBus(rdBus),
    .descValid(rdValid), .descReady(rdReady), .statBus(rdSt), .statValid(rdStV), .lastDesc(rdLast),
    .takenCnt(rdCnt));
  engine_model u_engine_model_wr (.clk_sys(clk_sys), .reset_n(reset_n), .holdOff(holdWr), .descBus(wrBus),
    .descValid(wrValid), .descReady(wrReady), .statBus(wrSt), .statValid(wrStV), .lastDesc(wrLast),
    .takenCnt(wrCnt));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [DESC_W-1:0] got, input logic [DESC_W-1:0] want);
    cmp_count++;
    if (got !== want)
    begin
      err_total++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, want);
    end
  endtask
  task automatic wbAccess(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wbAck !== 1'b1 && n < 20);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (n >= 20)
    begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wbAccess(1'b1, adr, dat, d);
  endtask
  task automatic rdChk(input logic [7:0] adr, input logic [31:0] want);
    logic [31:0] d;
    wbAccess(1'b0, adr, 32'h0, d);
    chk({128'h0, d}, {128'h0, want});
  endtask
  task automatic waitFor(input int which, input logic [7:0] target);
    int n;
    n = 0;
    while (((which == 0) ? rdCnt : (which == 1) ? wrCnt : {7'h0, irq}) !== target && n < 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 50)
    begin
      err_total++;
      report_and_stop();
    end
  endtask
  // ------
  // main sequence
  // ------
  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdChk(REG_IRQ_STAT, 32'h0);
    rdChk(8'h40, 32'h0);
    wr(REG_IRQ_MASK, 32'h7);
    wr(REG_SRC_LO, 32'h10000004);
    wr(REG_SRC_HI, 32'h1);
    wr(REG_DST_LO, 32'h20000008);
    wr(REG_DST_HI, 32'h3);
    wr(REG_LEN, 32'h3FFFF);
    wr(REG_TAG, 32'h1AA);
    wr(REG_CMD, 32'h1);
    waitFor(0, 8'h1);
    exp = {1'b0, 5'h0, 8'hAA, 18'h3FFFF, 32'h3, 32'h20000008, 32'h1, 32'h10000004};
    chk(rdLast, exp);
    waitFor(2, 8'h1);
    rdChk(REG_RD_LAST, 32'h1AA);
    rdChk(REG_IRQ_STAT, 32'h1);
    wr(REG_IRQ_STAT, 32'h1);
    rdChk(REG_IRQ_STAT, 32'h0);
    // hold the write engine off before launching, so no old ready grants a slot
    holdWr <= 1'b1;
    wr(REG_SRC_LO, 32'hCAFE0003);
    wr(REG_CMD, 32'h2);
    repeat (8) @(posedge clk_sys);
    chk({152'h0, wrCnt}, 160'h0);
    rdChk(REG_STATE, 32'h14);
    wr(REG_CMD, 32'h2);
    rdChk(REG_IRQ_STAT, 32'h4);
    wr(REG_IRQ_STAT, 32'h4);
    holdWr <= 1'b0;
    waitFor(1, 8'h1);
    exp[159] = 1'b1;
    exp[31:0] = 32'hCAFE0003;
    chk(wrLast, exp);
    waitFor(2, 8'h1);
    rdChk(REG_WR_LAST, 32'h1AA);
    wr(REG_IRQ_STAT, 32'h7);
    wr(REG_IRQ_MASK, 32'h0);
    wr(REG_LEN, 32'h0);
    wr(REG_CMD, 32'h1);
    rdChk(REG_IRQ_STAT, 32'h4);
    chk({159'h0, irq}, 160'h0);
    wr(REG_IRQ_STAT, 32'h4);
    wr(REG_LEN, 32'h5);
    wr(REG_DST_LO, 32'h20000002);
    wr(REG_IRQ_MASK, 32'h4);
    wr(REG_CMD, 32'h1);
    waitFor(2, 8'h1);
    rdChk(REG_IRQ_STAT, 32'h4);
    chk({152'h0, rdCnt}, 160'h1);
    report_and_stop();
  end
endmodule
bind dma_descriptor_stream_port dma_descriptor_stream_port_monitor u_dma_descriptor_stream_port_monitor (
  .clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rdDescInBus(rdDescInBus),
  .rdDescInValid(rdDescInValid), .rdDescInReady(rdDescInReady), .wrDescInBus(wrDescInBus),
  .wrDescInValid(wrDescInValid), .wrDescInReady(wrDescInReady));
`default_nettype wire
